// *** srs_exec.sv ***
// Execution unit: push, exits, rotates, bit force, short branch, subtract, swap, trade
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module srs_exec (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        insn_valid,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand,
    input  wire logic [15:0] insn_pc,
    input  wire logic [7:0]  mem_rdata,
    output logic             insn_ready,
    output logic             done,
    output logic [7:0]       mem_addr,
    output logic [7:0]       mem_wdata,
    output logic             mem_we,
    output logic             mem_re,
    output logic [7:0]       bit_addr,
    output logic             bit_set,
    output logic [15:0]      pc,
    output logic             pc_load,
    output logic [7:0]       acc,
    output logic [7:0]       program_status_word,
    output logic [7:0]       sp,
    output logic             irq_release,
    output logic             irq_hold
);
    // ==========================================================
    // State
    srs_pkg::srs_state_t state_q, state_d;
    logic [7:0]  acc_q, acc_d, psw_q, psw_d, sp_q, sp_d, op_q, op_d, hi_q, hi_d;
    logic [7:0]  addr_q, addr_d, wdata_q, wdata_d, baddr_q, baddr_d;
    logic [15:0] pc_q, pc_d;
    logic        we_q, we_d, re_q, re_d, bset_q, bset_d, pcl_q, pcl_d;
    logic        done_q, done_d, rdy_q, rdy_d, rel_q, rel_d, hold_q, hold_d;
    logic [7:0]  rbank;
    logic        accept;

    // ==========================================================
    // Subtract with borrow: {carry, aux, overflow, result}
    function automatic logic [10:0] subtract_borrow_f(input logic [7:0] a, input logic [7:0] b,
                                           input logic cy);
        logic [8:0] full;
        logic [4:0] low4;
        logic [7:0] low7;
        full = {1'b0, a} - {1'b0, b} - {8'h00, cy};
        low4 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy};
        low7 = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, cy};
        return {full[8], low4[4], low7[7] ^ full[8], full[7:0]};
    endfunction : subtract_borrow_f
    assign accept = insn_valid && (state_q == srs_pkg::ST_IDLE);
    assign rbank  = {3'h0, psw_q[srs_pkg::PSW_RS_HI:srs_pkg::PSW_RS_LO], 3'h0};
    // ==========================================================
    // Sequencer
    always_comb begin
        logic [10:0] sb;
        sb      = 11'h000;
        state_d = state_q;
        acc_d   = acc_q;
        psw_d   = psw_q;
        sp_d    = sp_q;
        pc_d    = pc_q;
        op_d    = op_q;
        hi_d    = hi_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        baddr_d = baddr_q;
        we_d    = 1'b0;
        re_d    = 1'b0;
        bset_d  = 1'b0;
        pcl_d   = 1'b0;
        done_d  = 1'b0;
        rel_d   = 1'b0;
        hold_d  = hold_q;
        case (state_q)
            srs_pkg::ST_IDLE: begin
                if (insn_valid) begin
                    op_d   = opcode;
                    done_d = 1'b1;
                    if (opcode == srs_pkg::OP_PUSH) begin
                        sp_d    = sp_q + srs_pkg::SP_STEP;
                        addr_d  = operand;
                        re_d    = 1'b1;
                        done_d  = 1'b0;
                        state_d = srs_pkg::ST_PUSH;
                    end else if (opcode == srs_pkg::OP_SUB_EXIT ||
                                 opcode == srs_pkg::OP_INT_EXIT) begin
                        addr_d  = sp_q;
                        re_d    = 1'b1;
                        sp_d    = sp_q - srs_pkg::SP_STEP;
                        done_d  = 1'b0;
                        state_d = srs_pkg::ST_POP_HI;
                    end else if (opcode == srs_pkg::OP_ROT_L) begin
                        // bit 7 wraps to bit 0
                        acc_d = {acc_q[6:0], acc_q[7]};
                    end else if (opcode == srs_pkg::OP_ROT_LC) begin
                        acc_d = {acc_q[6:0], psw_q[srs_pkg::PSW_CY]};
                        psw_d[srs_pkg::PSW_CY] = acc_q[7];
                    end else if (opcode == srs_pkg::OP_ROT_R) begin
                        // bit 0 wraps to bit 7
                        acc_d = {acc_q[0], acc_q[7:1]};
                    end else if (opcode == srs_pkg::OP_ROT_RC) begin
                        acc_d = {psw_q[srs_pkg::PSW_CY], acc_q[7:1]};
                        psw_d[srs_pkg::PSW_CY] = acc_q[0];
                    end else if (opcode == srs_pkg::OP_FORCE_C) begin
                        psw_d[srs_pkg::PSW_CY] = 1'b1;
                    end else if (opcode == srs_pkg::OP_FORCE_B) begin
                        baddr_d = operand;
                        bset_d  = 1'b1;
                    end else if (opcode == srs_pkg::OP_SBRANCH) begin
                        pc_d  = insn_pc + srs_pkg::BRANCH_STEP + {{8{operand[7]}}, operand};
                        pcl_d = 1'b1;
                    end else if (opcode == srs_pkg::OP_SUBTRACT_BORROW_IM) begin
                        sb    = subtract_borrow_f(acc_q, operand, psw_q[srs_pkg::PSW_CY]);
                        acc_d = sb[7:0];
                        psw_d[srs_pkg::PSW_CY]  = sb[10];
                        psw_d[srs_pkg::PSW_AUX] = sb[9];
                        psw_d[srs_pkg::PSW_OV]  = sb[8];
                    end else if (opcode == srs_pkg::OP_NSWAP) begin
                        acc_d = {acc_q[3:0], acc_q[7:4]};
                    end else if (opcode == srs_pkg::OP_SUBTRACT_BORROW_DI ||
                                 opcode == srs_pkg::OP_TRADE_DI) begin
                        addr_d  = operand;
                        re_d    = 1'b1;
                        done_d  = 1'b0;
                        state_d = srs_pkg::ST_RD_OPN;
                    end else if (opcode[7:3] == srs_pkg::OP_SUBTRACT_BORROW_RN ||
                                 opcode[7:3] == srs_pkg::OP_TRADE_RN) begin
                        addr_d  = rbank | {5'h00, opcode[2:0]};
                        re_d    = 1'b1;
                        done_d  = 1'b0;
                        state_d = srs_pkg::ST_RD_OPN;
                    end else if (opcode[7:1] == srs_pkg::OP_SUBTRACT_BORROW_IN ||
                                 opcode[7:1] == srs_pkg::OP_TRADE_IN) begin
                        addr_d  = rbank | {7'h00, opcode[0]};
                        re_d    = 1'b1;
                        done_d  = 1'b0;
                        state_d = srs_pkg::ST_RD_PTR;
                    end
                end
            end
            srs_pkg::ST_RD_PTR: begin
                addr_d  = mem_rdata;
                re_d    = 1'b1;
                state_d = srs_pkg::ST_RD_OPN;
            end
            srs_pkg::ST_RD_OPN: begin
                done_d  = 1'b1;
                state_d = srs_pkg::ST_IDLE;
                if (op_q[7:6] == 2'h2) begin
                    sb    = subtract_borrow_f(acc_q, mem_rdata, psw_q[srs_pkg::PSW_CY]);
                    acc_d = sb[7:0];
                    psw_d[srs_pkg::PSW_CY]  = sb[10];
                    psw_d[srs_pkg::PSW_AUX] = sb[9];
                    psw_d[srs_pkg::PSW_OV]  = sb[8];
                end else begin
                    // old accumulator goes back to same address
                    acc_d   = mem_rdata;
                    wdata_d = acc_q;
                    we_d    = 1'b1;
                end
            end
            srs_pkg::ST_PUSH: begin
                addr_d  = sp_q;
                wdata_d = mem_rdata;
                we_d    = 1'b1;
                done_d  = 1'b1;
                state_d = srs_pkg::ST_IDLE;
            end
            srs_pkg::ST_POP_HI: begin
                // low byte below the high byte
                hi_d    = mem_rdata;
                addr_d  = sp_q;
                re_d    = 1'b1;
                sp_d    = sp_q - srs_pkg::SP_STEP;
                state_d = srs_pkg::ST_POP_LO;
            end
            srs_pkg::ST_POP_LO: begin
                pc_d    = {hi_q, mem_rdata};
                pcl_d   = 1'b1;
                done_d  = 1'b1;
                state_d = srs_pkg::ST_IDLE;
                if (op_q == srs_pkg::OP_INT_EXIT) begin
                    rel_d  = 1'b1;
                    hold_d = 1'b1;
                end
            end
            default: state_d = srs_pkg::ST_IDLE;
        endcase
        // hold drops once a further instruction completes
        if (done_d && !rel_d) begin
            hold_d = 1'b0;
        end
        rdy_d = (state_d == srs_pkg::ST_IDLE);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= srs_pkg::ST_IDLE;
            acc_q   <= srs_pkg::ACC_RST;
            psw_q   <= srs_pkg::PSW_RST;
            sp_q    <= srs_pkg::SP_RST;
            pc_q    <= srs_pkg::PC_RST;
            op_q    <= 8'h00;
            hi_q    <= 8'h00;
            addr_q  <= 8'h00;
            wdata_q <= 8'h00;
            baddr_q <= 8'h00;
            we_q    <= 1'b0;
            re_q    <= 1'b0;
            bset_q  <= 1'b0;
            pcl_q   <= 1'b0;
            done_q  <= 1'b0;
            rdy_q   <= 1'b1;
            rel_q   <= 1'b0;
            hold_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            acc_q   <= acc_d;
            psw_q   <= psw_d;
            sp_q    <= sp_d;
            pc_q    <= pc_d;
            op_q    <= op_d;
            hi_q    <= hi_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            baddr_q <= baddr_d;
            we_q    <= we_d;
            re_q    <= re_d;
            bset_q  <= bset_d;
            pcl_q   <= pcl_d;
            done_q  <= done_d;
            rdy_q   <= rdy_d;
            rel_q   <= rel_d;
            hold_q  <= hold_d;
        end
    end

    assign insn_ready  = rdy_q;
    assign done        = done_q;
    assign mem_addr    = addr_q;
    assign mem_wdata   = wdata_q;
    assign mem_we      = we_q;
    assign mem_re      = re_q;
    assign bit_addr    = baddr_q;
    assign bit_set     = bset_q;
    assign pc          = pc_q;
    assign pc_load     = pcl_q;
    assign acc         = acc_q;
    assign program_status_word         = psw_q;
    assign sp          = sp_q;
    assign irq_release = rel_q;
    assign irq_hold    = hold_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence pop_walk_s;
        state_q == srs_pkg::ST_POP_HI ##1 state_q == srs_pkg::ST_POP_LO ##1 pcl_q;
    endsequence
    push_store_a: assert property (accept && opcode == srs_pkg::OP_PUSH |=>
        sp_q == $past(sp_q) + 8'h01 ##1 (we_q && addr_q == sp_q))
        else $error("push did not store at raised pointer");
    exit_pops_a: assert property (accept && opcode == srs_pkg::OP_SUB_EXIT |=>
        pop_walk_s ##0 (sp_q == $past(sp_q, 3) - 8'h02 && !rel_q))
        else $error("subroutine exit pop sequence wrong");
    int_release_a: assert property (accept && opcode == srs_pkg::OP_INT_EXIT |=>
        pop_walk_s ##0 rel_q)
        else $error("interrupt exit did not release level");
    exit_psw_a: assert property (accept && opcode == srs_pkg::OP_INT_EXIT |=>
        $stable(psw_q)[*3])
        else $error("interrupt exit changed status word");
    // hold stays until next instruction completes
    hold_span_a: assert property (rel_q |-> hold_q until (done_q && !rel_q))
        else $error("interrupt hold dropped early");
    hold_bound_a: assert property ($past(hold_q) && done_q && !rel_q |-> !hold_q)
        else $error("interrupt hold outlived next instruction");
    rot_left_a: assert property (accept && opcode == srs_pkg::OP_ROT_L |=>
        acc_q == {$past(acc_q[6:0]), $past(acc_q[7])} && $stable(psw_q))
        else $error("rotate left wrong");
    rot_rcarry_a: assert property (accept && opcode == srs_pkg::OP_ROT_RC |=>
        psw_q[7] == $past(acc_q) % 2)
        else $error("rotate right carry wrong");
    branch_tgt_a: assert property (accept && opcode == srs_pkg::OP_SBRANCH |=>
        pcl_q && pc_q == $past(insn_pc) + 16'h0002 + {{8{$past(operand) > 8'h7F}}, $past(operand)})
        else $error("short branch target wrong");
    subtract_borrow_carry_a: assert property (accept && opcode == srs_pkg::OP_SUBTRACT_BORROW_IM |=>
        psw_q[7] == ({1'b0, $past(acc_q)} < {1'b0, $past(operand)} + {8'h00, $past(psw_q) > 8'h7F}))
        else $error("subtract carry wrong");
    nib_swap_a: assert property (accept && opcode == srs_pkg::OP_NSWAP |=>
        acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])} && $stable(psw_q) && done_q)
        else $error("nibble swap wrong");
endmodule : srs_exec
`default_nettype wire

// *** srs_exec_bench.sv ***
// Self-checking bench for the execution unit with a data memory model
`timescale 1ns/1ps
`default_nettype none
module srs_exec_bench;
    // ==========================================================
    // Signals
    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  program_status_word;
        logic [7:0]  sp;
        logic [15:0] pc;
        logic        ldpc;
        logic        rel;
        logic        bset;
        logic [7:0]  baddr;
    } srs_note_t;
    logic        clk, arst_n, insn_valid, insn_ready, done;
    logic        mem_we, mem_re, bit_set, pc_load, irq_release, irq_hold;
    logic [7:0]  opcode, operand, mem_rdata, mem_addr, mem_wdata, bit_addr;
    logic [7:0]  acc, program_status_word, sp, m_acc, m_psw, m_sp;
    logic [15:0] insn_pc, pc;
    logic [31:0] lfsr_q;
    logic [7:0]  sh [256];
    logic [7:0]  ops [15];
    srs_note_t   notes [$];
    srs_note_t   mon_e;
    int          err_total, samples_checked;
    // ==========================================================
    // Design and memory
    srs_exec uut (.clk(clk), .arst_n(arst_n), .insn_valid(insn_valid), .opcode(opcode),
        .operand(operand), .insn_pc(insn_pc), .mem_rdata(mem_rdata),
        .insn_ready(insn_ready), .done(done), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .bit_addr(bit_addr), .bit_set(bit_set), .pc(pc),
        .pc_load(pc_load), .acc(acc), .program_status_word(program_status_word), .sp(sp), .irq_release(irq_release),
        .irq_hold(irq_hold));
    srs_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // Helpers
    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[7:0];
    endfunction : rnd
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // Reference model notes the outcome, then issues the instruction
    task automatic run(input logic [7:0] op, input logic [7:0] opr, input logic [15:0] ipc);
        srs_note_t   e;
        logic [7:0]  a;
        logic [7:0]  v;
        logic [8:0]  d;
        logic        c;
        int          n;
        e = '0;
        c = m_psw[7];
        a = opr;
        if (op[7:3] == srs_pkg::OP_SUBTRACT_BORROW_RN || op[7:3] == srs_pkg::OP_TRADE_RN)
            a = {5'h00, op[2:0]};
        else if (op[7:1] == srs_pkg::OP_SUBTRACT_BORROW_IN || op[7:1] == srs_pkg::OP_TRADE_IN)
            a = sh[{7'h00, op[0]}];
        v = (op == srs_pkg::OP_SUBTRACT_BORROW_IM) ? opr : sh[a];
        if (op == srs_pkg::OP_ROT_L)
            m_acc = {m_acc[6:0], m_acc[7]};
        else if (op == srs_pkg::OP_ROT_LC)
            {m_psw[7], m_acc} = {m_acc, c};
        else if (op == srs_pkg::OP_ROT_R)
            m_acc = {m_acc[0], m_acc[7:1]};
        else if (op == srs_pkg::OP_ROT_RC)
            {m_acc, m_psw[7]} = {c, m_acc};
        else if (op == srs_pkg::OP_FORCE_C)
            m_psw[7] = 1'b1;
        else if (op == srs_pkg::OP_FORCE_B) begin
            e.bset = 1'b1;
            e.baddr = opr;
        end else if (op == srs_pkg::OP_NSWAP)
            m_acc = {m_acc[3:0], m_acc[7:4]};
        else if (op == srs_pkg::OP_SUBTRACT_BORROW_IM || op == srs_pkg::OP_SUBTRACT_BORROW_DI
                 || op[7:1] == srs_pkg::OP_SUBTRACT_BORROW_IN || op[7:3] == srs_pkg::OP_SUBTRACT_BORROW_RN) begin
            d = {1'b0, m_acc} - {1'b0, v} - {8'h00, c};
            m_psw[6] = {1'b0, m_acc[3:0]} < ({1'b0, v[3:0]} + {4'h0, c});
            m_psw[2] = d[8] ^ ({1'b0, m_acc[6:0]} < ({1'b0, v[6:0]} + {7'h00, c}));
            m_psw[7] = d[8];
            m_acc = d[7:0];
        end else if (op == srs_pkg::OP_TRADE_DI || op[7:1] == srs_pkg::OP_TRADE_IN
                     || op[7:3] == srs_pkg::OP_TRADE_RN) begin
            sh[a] = m_acc;
            m_acc = v;
        end else if (op == srs_pkg::OP_PUSH) begin
            m_sp = m_sp + 8'h01;
            sh[m_sp] = sh[opr];
        end else if (op == srs_pkg::OP_SUB_EXIT || op == srs_pkg::OP_INT_EXIT) begin
            e.pc = {sh[m_sp], sh[m_sp - 8'h01]};
            e.ldpc = 1'b1;
            e.rel = (op == srs_pkg::OP_INT_EXIT);
            m_sp = m_sp - 8'h02;
        end else if (op == srs_pkg::OP_SBRANCH) begin
            e.pc = ipc + 16'h0002 + {{8{opr[7]}}, opr};
            e.ldpc = 1'b1;
        end
        e.acc = m_acc;
        e.program_status_word = m_psw;
        e.sp = m_sp;
        notes.push_back(e);
        insn_valid <= 1'b1;
        opcode <= op;
        operand <= opr;
        insn_pc <= ipc;
        @(posedge clk);
        insn_valid <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            n++;
        end
        if (n >= 8)
            cmp(16'h0001, 16'h0000, "no completion");
    endtask : run
    // ==========================================================
    // Result monitor
    always @(posedge clk) begin
        if (arst_n === 1'b1 && done === 1'b1) begin
            if (notes.size() == 0)
                cmp(16'h0001, 16'h0000, "unexpected completion");
            else begin
                mon_e = notes.pop_front();
                cmp({8'h00, acc}, {8'h00, mon_e.acc}, "acc");
                cmp({8'h00, program_status_word}, {8'h00, mon_e.program_status_word}, "psw");
                cmp({8'h00, sp}, {8'h00, mon_e.sp}, "sp");
                cmp({15'h0000, insn_ready}, 16'h0001, "ready at completion");
                cmp({15'h0000, pc_load}, {15'h0000, mon_e.ldpc}, "pc_load");
                if (mon_e.ldpc)
                    cmp(pc, mon_e.pc, "pc");
                cmp({15'h0000, bit_set}, {15'h0000, mon_e.bset}, "bit_set");
                if (mon_e.bset)
                    cmp({8'h00, bit_addr}, {8'h00, mon_e.baddr}, "bit_addr");
                cmp({15'h0000, irq_release}, {15'h0000, mon_e.rel}, "release");
                if (mon_e.rel)
                    cmp({15'h0000, irq_hold}, 16'h0001, "hold set");
            end
        end
    end
    // ==========================================================
    // Watchdog sized well past the expected run
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        test_done();
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] r;
        arst_n = 1'b0;
        insn_valid = 1'b0;
        opcode = 8'h00;
        operand = 8'h00;
        insn_pc = 16'h0000;
        lfsr_q = 32'd95247;
        err_total = 0;
        samples_checked = 0;
        ops = '{srs_pkg::OP_ROT_L, srs_pkg::OP_ROT_LC, srs_pkg::OP_ROT_R, srs_pkg::OP_ROT_RC,
                srs_pkg::OP_FORCE_C, srs_pkg::OP_NSWAP, srs_pkg::OP_SUBTRACT_BORROW_IM,
                srs_pkg::OP_SUBTRACT_BORROW_DI, {srs_pkg::OP_SUBTRACT_BORROW_IN, 1'b0}, {srs_pkg::OP_SUBTRACT_BORROW_IN, 1'b1},
                {srs_pkg::OP_SUBTRACT_BORROW_RN, 3'h5}, srs_pkg::OP_TRADE_DI,
                {srs_pkg::OP_TRADE_IN, 1'b1}, {srs_pkg::OP_TRADE_RN, 3'h2},
                srs_pkg::OP_FORCE_B};
        for (int i = 0; i < 256; i++) begin
            r = rnd();
            sh[i] = r;
            mem.ram[i] = r;
        end
        m_acc = srs_pkg::ACC_RST;
        m_psw = srs_pkg::PSW_RST;
        m_sp = srs_pkg::SP_RST;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        cmp({8'h00, sp}, {8'h00, srs_pkg::SP_RST}, "sp after reset");
        cmp({15'h0000, insn_ready}, 16'h0001, "ready after reset");
        // Every rotate, force, swap, subtract and trade form, random data
        for (int k = 0; k < 90; k++) begin
            r = rnd();
            run(ops[k % 15], r, 16'h0000);
        end
        // Displacement extremes, a branch to itself, an unassigned code, then pushes and both exits
        run(srs_pkg::OP_SBRANCH, 8'h80, 16'h1234);
        run(srs_pkg::OP_SBRANCH, 8'h7F, 16'hFFF0);
        run(srs_pkg::OP_SBRANCH, 8'hFE, 16'h0100);
        run(8'hA5, 8'h00, 16'h0000);
        run(srs_pkg::OP_PUSH, 8'h30, 16'h0000);
        run(srs_pkg::OP_PUSH, 8'h31, 16'h0000);
        run(srs_pkg::OP_SUB_EXIT, 8'h00, 16'h0000);
        run(srs_pkg::OP_PUSH, 8'h32, 16'h0000);
        run(srs_pkg::OP_PUSH, 8'h33, 16'h0000);
        run(srs_pkg::OP_INT_EXIT, 8'h00, 16'h0000);
        run(srs_pkg::OP_ROT_L, 8'h00, 16'h0000);
        @(posedge clk);
        cmp({15'h0000, irq_hold}, 16'h0000, "hold cleared");
        // Fill the stack until the pointer wraps, then pop across the wrap
        while (m_sp !== 8'h00) begin
            r = rnd();
            run(srs_pkg::OP_PUSH, r, 16'h0000);
        end
        run(srs_pkg::OP_INT_EXIT, 8'h00, 16'h0000);
        for (int i = 0; i < 256; i++)
            cmp({8'h00, mem.ram[i]}, {8'h00, sh[i]}, "memory");
        test_done();
    end
endmodule : srs_exec_bench
`default_nettype wire

// *** srs_mem_model.sv ***
// Behavioural internal data memory facing the execution unit
`timescale 1ns/1ps
`default_nettype none
module srs_mem_model (
    input  wire logic       clk,
    input  wire logic [7:0] mem_addr,
    input  wire logic [7:0] mem_wdata,
    input  wire logic       mem_we,
    input  wire logic       mem_re,
    output wire logic [7:0] mem_rdata
);
    // ==========================================================
    // Storage, preloaded by the bench
    logic [7:0] ram [256];
    // Asynchronous read while the strobe stands; inverse otherwise, so stale use shows
    assign mem_rdata = mem_re ? ram[mem_addr] : ~ram[mem_addr];
    always @(posedge clk) begin
        if (mem_we)
            ram[mem_addr] <= mem_wdata;
    end
endmodule : srs_mem_model
`default_nettype wire

// *** srs_pkg.sv ***
// Constants, opcodes and state codes for the stack/rotate/subtract execution unit
package srs_pkg;
    // ==========================================================
    // Reset values
    localparam logic [7:0]  SP_RST     = 8'h07;
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic [7:0]  PSW_RST    = 8'h00;
    localparam logic [15:0] PC_RST     = 16'h0000;
    // ==========================================================
    // Status word bit positions
    localparam int          PSW_CY     = 7;
    localparam int          PSW_AUX    = 6;
    localparam int          PSW_RS_HI  = 4;
    localparam int          PSW_RS_LO  = 3;
    localparam int          PSW_OV     = 2;
    // ==========================================================
    // Opcodes
    localparam logic [7:0]  OP_PUSH    = 8'hC0;
    localparam logic [7:0]  OP_SUB_EXIT = 8'h22;
    localparam logic [7:0]  OP_INT_EXIT = 8'h32;
    localparam logic [7:0]  OP_ROT_L   = 8'h23;
    localparam logic [7:0]  OP_ROT_LC  = 8'h33;
    localparam logic [7:0]  OP_ROT_R   = 8'h03;
    localparam logic [7:0]  OP_ROT_RC  = 8'h13;
    localparam logic [7:0]  OP_FORCE_C = 8'hD3;
    localparam logic [7:0]  OP_FORCE_B = 8'hD2;
    localparam logic [7:0]  OP_SBRANCH = 8'h80;
    localparam logic [7:0]  OP_SUBTRACT_BORROW_IM = 8'h94;
    localparam logic [7:0]  OP_SUBTRACT_BORROW_DI = 8'h95;
    localparam logic [6:0]  OP_SUBTRACT_BORROW_IN = 7'h4B;
    localparam logic [4:0]  OP_SUBTRACT_BORROW_RN = 5'h13;
    localparam logic [7:0]  OP_NSWAP   = 8'hC4;
    localparam logic [7:0]  OP_TRADE_DI = 8'hC5;
    localparam logic [6:0]  OP_TRADE_IN = 7'h63;
    localparam logic [4:0]  OP_TRADE_RN = 5'h19;
    // ==========================================================
    // Branch step and stack step
    localparam logic [15:0] BRANCH_STEP = 16'h0002;
    localparam logic [7:0]  SP_STEP    = 8'h01;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RD_PTR = 3'b001,
        ST_RD_OPN = 3'b010,
        ST_PUSH   = 3'b011,
        ST_POP_HI = 3'b100,
        ST_POP_LO = 3'b101
    } srs_state_t;
endpackage : srs_pkg
